// ---- rtl/vu_port.sv ----
// Virtual serial port: host registers, interrupt priority, line framing and status.
`timescale 1ns/1ps
`include "vu_regs.svh"

module vu_port (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Host I/O port
	input wire logic [2:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	output logic host_irq,
	// Serial line
	input wire logic serial_rx,
	output logic serial_tx,
	// Handshake inputs and controller pins
	input wire logic cts_pin,
	input wire logic dsr_pin,
	input wire logic ri_pin,
	input wire logic dcd_pin,
	output logic term_ready_pin,
	output logic req_send_pin,
	// Ready indicators, active low
	output logic rx_ready_indicator_n,
	output logic tx_ready_indicator_n
);
	// ==========================================
	// Shared helpers
	function automatic logic [3:0] char_len(input logic [7:0] f);
		return `VU_CHAR_MIN + {2'b00, f[1:0]};
	endfunction

	function automatic logic parity_of(input logic [7:0] d, input logic [7:0] f);
		logic x;
		x = ^(d & (8'hff >> (2'h3 - f[1:0])));
		if (f[`VU_FMT_FORCED]) begin
			return !f[`VU_FMT_EVEN];
		end
		return f[`VU_FMT_EVEN] ? x : !x;
	endfunction

	// ==========================================
	// Registers and decode
	logic [7:0] fmt, ier, hsk, dll, divisor_high;
	logic ready_mode;
	logic [1:0] trig_sel;
	logic divisor_access_select, wr_data, rd_data, rd_status, rd_ident, rd_mstat, wr_ctl;
	logic rx_flush, tx_flush;

	assign divisor_access_select = fmt[`VU_FMT_DIVISOR_ACCESS_SELECT];
	assign wr_data = host_wr && host_addr == `VU_ADDR_DATA && !divisor_access_select;
	assign rd_data = host_rd && host_addr == `VU_ADDR_DATA && !divisor_access_select;
	assign rd_status = host_rd && host_addr == `VU_ADDR_STATUS;
	assign rd_ident = host_rd && host_addr == `VU_ADDR_IDENT;
	assign rd_mstat = host_rd && host_addr == `VU_ADDR_MSTAT;
	assign wr_ctl = host_wr && host_addr == `VU_ADDR_IDENT;
	assign rx_flush = wr_ctl && host_wdata[`VU_FCR_RX_FLUSH];
	assign tx_flush = wr_ctl && host_wdata[`VU_FCR_TX_FLUSH];

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			fmt <= `VU_RST_BYTE;
			ier <= `VU_RST_BYTE;
			hsk <= `VU_RST_BYTE;
			dll <= `VU_RST_BYTE;
			divisor_high <= `VU_RST_BYTE;
			ready_mode <= 1'b0;
			trig_sel <= 2'b00;
		end else if (host_wr) begin
			case (host_addr)
				`VU_ADDR_DATA: if (divisor_access_select) begin
					dll <= host_wdata;
				end
				`VU_ADDR_IER: if (divisor_access_select) begin
					divisor_high <= host_wdata;
				end else begin
					ier <= {4'h0, host_wdata[3:0]};
				end
				`VU_ADDR_IDENT: begin
					// The FIFO enable bit is not stored: FIFO mode cannot be left.
					ready_mode <= host_wdata[`VU_FCR_READY_MODE];
					trig_sel <= {host_wdata[`VU_FCR_TRIG_A], host_wdata[`VU_FCR_TRIG_B]};
				end
				`VU_ADDR_FMT: fmt <= host_wdata;
				`VU_ADDR_HSK: hsk <= {6'h00, host_wdata[1:0]};
				default: ;
			endcase
		end
	end

	// ==========================================
	// Pin synchronisers: line, cts, dsr, ri, dcd
	logic [4:0] pin_meta, pin_sync, pin_prev;
	logic [3:0] delta;
	logic rx_line;

	assign rx_line = pin_sync[4];

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pin_meta <= `VU_PIN_IDLE;
			pin_sync <= `VU_PIN_IDLE;
			pin_prev <= `VU_PIN_IDLE;
		end else begin
			pin_meta <= {serial_rx, cts_pin, dsr_pin, ri_pin, dcd_pin};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Change bits: cts, dsr, ri rising, dcd; a change in the read cycle survives.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			delta <= 4'h0;
		end else begin
			delta <= (rd_mstat ? 4'h0 : delta) | {
				pin_sync[0] ^ pin_prev[0],
				pin_sync[1] & !pin_prev[1],
				pin_sync[2] ^ pin_prev[2],
				pin_sync[3] ^ pin_prev[3]};
		end
	end

	// ==========================================
	// Baud generator and FIFOs
	logic tick16;
	logic rx_push;
	logic [10:0] rx_word, rx_head;
	logic [`VU_CNT_W-1:0] rx_count, tx_count;
	logic rx_full, rx_empty, tx_full, tx_empty, tx_pop;
	logic [7:0] tx_head;

	vu_baud u_baud (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.divisor({divisor_high, dll}),
		.tick16(tick16)
	);

	vu_fifo #(.WIDTH(11)) u_rx_fifo (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.push(rx_push),
		.pop(rd_data),
		.flush(rx_flush),
		.din(rx_word),
		.dout(rx_head),
		.count(rx_count),
		.full(rx_full),
		.empty(rx_empty)
	);

	vu_fifo #(.WIDTH(8)) u_tx_fifo (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.push(wr_data),
		.pop(tx_pop),
		.flush(tx_flush),
		.din(host_wdata),
		.dout(tx_head),
		.count(tx_count),
		.full(tx_full),
		.empty(tx_empty)
	);

	// ==========================================
	// Receiver
	vu_pkg::vu_rx_state_e rx_st;
	logic [4:0] rx_tick;
	logic [2:0] rx_bit;
	logic [7:0] rx_shift;
	logic rx_par_bad, rx_any_high, rx_brk;

	assign rx_brk = !rx_any_high && !rx_line;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rx_st <= vu_pkg::vu_rx_idle;
			rx_tick <= '0;
			rx_bit <= '0;
			rx_shift <= '0;
			rx_par_bad <= 1'b0;
			rx_any_high <= 1'b0;
			rx_push <= 1'b0;
			rx_word <= '0;
		end else begin
			rx_push <= 1'b0;
			if (tick16 && rx_st != vu_pkg::vu_rx_idle) begin
				rx_tick <= rx_tick + 5'h01;
			end
			case (rx_st)
				vu_pkg::vu_rx_idle: if (!rx_line) begin
					rx_st <= vu_pkg::vu_rx_start;
					rx_tick <= '0;
				end
				vu_pkg::vu_rx_start: if (tick16 && rx_tick == `VU_TICK_HALF) begin
					rx_tick <= '0;
					rx_bit <= '0;
					rx_shift <= '0;
					rx_par_bad <= 1'b0;
					rx_any_high <= 1'b0;
					rx_st <= rx_line ? vu_pkg::vu_rx_idle : vu_pkg::vu_rx_data;
				end
				vu_pkg::vu_rx_data: if (tick16 && rx_tick == `VU_TICK_LAST) begin
					rx_tick <= '0;
					rx_shift[rx_bit] <= rx_line;
					rx_any_high <= rx_any_high | rx_line;
					rx_bit <= rx_bit + 3'h1;
					if (rx_bit == 3'(char_len(fmt) - 4'h1)) begin
						rx_st <= fmt[`VU_FMT_PAR_ON] ? vu_pkg::vu_rx_par : vu_pkg::vu_rx_stop;
					end
				end
				vu_pkg::vu_rx_par: if (tick16 && rx_tick == `VU_TICK_LAST) begin
					rx_tick <= '0;
					rx_par_bad <= rx_line != parity_of(rx_shift, fmt);
					rx_any_high <= rx_any_high | rx_line;
					rx_st <= vu_pkg::vu_rx_stop;
				end
				vu_pkg::vu_rx_stop: if (tick16 && rx_tick == `VU_TICK_LAST) begin
					// Only the first stop bit is looked at; a frame low end to end is a break.
					rx_push <= 1'b1;
					rx_word <= {rx_brk, !rx_line && !rx_brk, rx_par_bad, rx_shift};
					rx_st <= rx_brk ? vu_pkg::vu_rx_wait : vu_pkg::vu_rx_idle;
				end
				vu_pkg::vu_rx_wait: if (rx_line) begin
					rx_st <= vu_pkg::vu_rx_idle;
				end
				default: rx_st <= vu_pkg::vu_rx_idle;
			endcase
		end
	end

	// ==========================================
	// Receive status: head errors are caught when a character reaches the head
	logic head_load, overrun;
	logic [2:0] head_err;
	logic [`VU_CNT_W-1:0] err_cnt;
	logic err_in, err_out;

	assign err_in = rx_push && |rx_word[10:8] && (!rx_full || rd_data);
	assign err_out = rd_data && !rx_empty && |rx_head[10:8];

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			head_load <= 1'b0;
			head_err <= 3'h0;
			overrun <= 1'b0;
		end else begin
			head_load <= (rd_data && rx_count > `VU_CNT_W'(1)) || (rx_push && rx_empty);
			head_err <= (rd_status ? 3'h0 : head_err) |
				(head_load && !rx_flush ? rx_head[10:8] : 3'h0);
			// The arriving character is dropped; the stored ones stay intact.
			overrun <= (rd_status ? 1'b0 : overrun) | (rx_push && rx_full && !rd_data);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || rx_flush) begin
			err_cnt <= '0;
		end else if (err_in && !err_out) begin
			err_cnt <= err_cnt + `VU_CNT_W'(1);
		end else if (err_out && !err_in) begin
			err_cnt <= err_cnt - `VU_CNT_W'(1);
		end
	end

	// ==========================================
	// Character timeout in oversample ticks
	logic [9:0] to_cnt, to_limit;
	logic to_hit;
	logic [3:0] frame_bits;

	assign frame_bits = char_len(fmt) + {3'h0, fmt[`VU_FMT_PAR_ON]} + 4'h2;
	assign to_limit = {frame_bits, 6'h00};
	assign to_hit = (to_cnt == to_limit) && !rx_empty;

	always_ff @(posedge core_clk) begin
		if (!rst_n || rx_push || rd_data || rx_flush) begin
			to_cnt <= '0;
		end else if (tick16 && !rx_empty && to_cnt != to_limit) begin
			to_cnt <= to_cnt + 10'h001;
		end
	end

	// ==========================================
	// Transmitter
	vu_pkg::vu_tx_state_e tx_st;
	logic [4:0] tx_tick, stop_last;
	logic [2:0] tx_bit;
	logic [7:0] tx_shift;
	logic tx_line, tx_idle;

	assign tx_idle = (tx_st == vu_pkg::vu_tx_idle);
	assign tx_pop = tx_idle && !tx_empty;
	assign stop_last = !fmt[`VU_FMT_STOP] ? `VU_TICK_LAST :
		(fmt[1:0] == 2'b00 ? `VU_STOP_ONE_HALF : `VU_STOP_TWO);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tx_st <= vu_pkg::vu_tx_idle;
			tx_tick <= '0;
			tx_bit <= '0;
			tx_shift <= '0;
			tx_line <= 1'b1;
		end else begin
			if (tick16 && !tx_idle) begin
				tx_tick <= tx_tick + 5'h01;
			end
			case (tx_st)
				vu_pkg::vu_tx_idle: if (tx_pop) begin
					tx_shift <= tx_head;
					tx_tick <= '0;
					tx_line <= 1'b0;
					tx_st <= vu_pkg::vu_tx_start;
				end
				vu_pkg::vu_tx_start: if (tick16 && tx_tick == `VU_TICK_LAST) begin
					tx_tick <= '0;
					tx_bit <= '0;
					tx_line <= tx_shift[0];
					tx_st <= vu_pkg::vu_tx_data;
				end
				vu_pkg::vu_tx_data: if (tick16 && tx_tick == `VU_TICK_LAST) begin
					tx_tick <= '0;
					tx_bit <= tx_bit + 3'h1;
					if (tx_bit == 3'(char_len(fmt) - 4'h1)) begin
						tx_line <= fmt[`VU_FMT_PAR_ON] ? parity_of(tx_shift, fmt) : 1'b1;
						tx_st <= fmt[`VU_FMT_PAR_ON] ? vu_pkg::vu_tx_par : vu_pkg::vu_tx_stop;
					end else begin
						tx_line <= tx_shift[tx_bit + 3'h1];
					end
				end
				vu_pkg::vu_tx_par: if (tick16 && tx_tick == `VU_TICK_LAST) begin
					tx_tick <= '0;
					tx_line <= 1'b1;
					tx_st <= vu_pkg::vu_tx_stop;
				end
				vu_pkg::vu_tx_stop: if (tick16 && tx_tick == stop_last) begin
					tx_st <= vu_pkg::vu_tx_idle;
				end
				default: tx_st <= vu_pkg::vu_tx_idle;
			endcase
		end
	end

	// ==========================================
	// Holding-empty interrupt flag; a new empty edge beats a clear in the same cycle
	logic tx_empty_q, tx_holding_empty_flag;
	logic [3:0] ident;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tx_empty_q <= 1'b1;
			tx_holding_empty_flag <= 1'b0;
		end else begin
			tx_empty_q <= tx_empty;
			tx_holding_empty_flag <= (tx_holding_empty_flag && !wr_data && !(rd_ident && ident == `VU_ID_TX_HOLDING_EMPTY)) ||
				(tx_empty && !tx_empty_q) ||
				(host_wr && host_addr == `VU_ADDR_IER && !divisor_access_select &&
				host_wdata[`VU_IER_TX_HOLDING_EMPTY] && !ier[`VU_IER_TX_HOLDING_EMPTY] && tx_empty);
		end
	end

	// ==========================================
	// Interrupt priority
	logic [4:0] trig_level;
	logic src_line, src_data, src_timeout, src_tx_holding_empty, src_modem;

	always_comb begin
		case (trig_sel)
			2'b00: trig_level = `VU_TRIG_1;
			2'b01: trig_level = `VU_TRIG_4;
			2'b10: trig_level = `VU_TRIG_8;
			default: trig_level = `VU_TRIG_14;
		endcase
	end

	assign src_line = ier[`VU_IER_LINE] && (overrun || |head_err);
	assign src_data = ier[`VU_IER_RX] && rx_count >= trig_level;
	assign src_timeout = ier[`VU_IER_RX] && to_hit;
	assign src_tx_holding_empty = ier[`VU_IER_TX_HOLDING_EMPTY] && tx_holding_empty_flag && tx_empty;
	assign src_modem = ier[`VU_IER_MODEM] && |delta;

	always_comb begin
		if (src_line) begin
			ident = `VU_ID_LINE;
		end else if (src_data) begin
			ident = `VU_ID_RXDATA;
		end else if (src_timeout) begin
			ident = `VU_ID_TIMEOUT;
		end else if (src_tx_holding_empty) begin
			ident = `VU_ID_TX_HOLDING_EMPTY;
		end else if (src_modem) begin
			ident = `VU_ID_MODEM;
		end else begin
			ident = `VU_ID_NONE;
		end
	end

	// ==========================================
	// Read data and registered outputs
	logic [7:0] status;

	assign status = {(err_cnt != '0) || |head_err,
		tx_empty && tx_idle,
		tx_empty,
		head_err, overrun,
		!rx_empty};

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			host_rdata <= `VU_RST_BYTE;
		end else if (host_rd) begin
			case (host_addr)
				`VU_ADDR_DATA: host_rdata <= divisor_access_select ? dll : rx_head[7:0];
				`VU_ADDR_IER: host_rdata <= divisor_access_select ? divisor_high : ier;
				`VU_ADDR_IDENT: host_rdata <= {`VU_ID_FIFO, ident};
				`VU_ADDR_HSK: host_rdata <= hsk;
				`VU_ADDR_STATUS: host_rdata <= status;
				`VU_ADDR_MSTAT: host_rdata <= {pin_sync[0], pin_sync[1], pin_sync[2],
					pin_sync[3], delta};
				default: host_rdata <= `VU_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			host_irq <= 1'b0;
			serial_tx <= 1'b1;
			term_ready_pin <= 1'b1;
			req_send_pin <= 1'b1;
			rx_ready_indicator_n <= 1'b1;
			tx_ready_indicator_n <= 1'b1;
		end else begin
			host_irq <= (ident != `VU_ID_NONE);
			serial_tx <= tx_line && !fmt[`VU_FMT_BREAK];
			term_ready_pin <= !hsk[`VU_HSK_DTR];
			req_send_pin <= !hsk[`VU_HSK_RTS];
			// Mode one waits for the trigger level or a timeout; mode zero for any byte.
			rx_ready_indicator_n <= ready_mode ? !(rx_count >= trig_level || to_hit) : rx_empty;
			tx_ready_indicator_n <= ready_mode ? tx_full : !tx_empty;
		end
	end
endmodule

// ---- rtl/vu_regs.svh ----
// Register offsets, field positions, codes and timing counts of the virtual serial port.
`ifndef VU_REGS_SVH
`define VU_REGS_SVH

// ==========================================
// Register offsets
`define VU_ADDR_DATA 3'h0
`define VU_ADDR_IER 3'h1
`define VU_ADDR_IDENT 3'h2
`define VU_ADDR_FMT 3'h3
`define VU_ADDR_HSK 3'h4
`define VU_ADDR_STATUS 3'h5
`define VU_ADDR_MSTAT 3'h6

// ==========================================
// Reset values
`define VU_RST_BYTE 8'h00
`define VU_RST_STATUS 8'h60
// The line idles high and the handshake inputs idle low, so leaving reset shows no change.
`define VU_PIN_IDLE 5'h10

// ==========================================
// Field positions
`define VU_FCR_RX_FLUSH 1
`define VU_FCR_TX_FLUSH 2
`define VU_FCR_READY_MODE 3
`define VU_FCR_TRIG_A 6
`define VU_FCR_TRIG_B 7
`define VU_FMT_STOP 2
`define VU_FMT_PAR_ON 3
`define VU_FMT_EVEN 4
`define VU_FMT_FORCED 5
`define VU_FMT_BREAK 6
`define VU_FMT_DIVISOR_ACCESS_SELECT 7
`define VU_IER_RX 0
`define VU_IER_TX_HOLDING_EMPTY 1
`define VU_IER_LINE 2
`define VU_IER_MODEM 3
`define VU_HSK_DTR 0
`define VU_HSK_RTS 1

// ==========================================
// Identification codes, low nibble; the upper nibble marks FIFO mode
`define VU_ID_FIFO 4'h8
`define VU_ID_NONE 4'h1
`define VU_ID_LINE 4'h6
`define VU_ID_RXDATA 4'h4
`define VU_ID_TIMEOUT 4'hc
`define VU_ID_TX_HOLDING_EMPTY 4'h2
`define VU_ID_MODEM 4'h0

// ==========================================
// Receive trigger levels
`define VU_TRIG_1 5'h01
`define VU_TRIG_4 5'h04
`define VU_TRIG_8 5'h08
`define VU_TRIG_14 5'h0e

// ==========================================
// FIFO geometry and bit timing in oversample ticks
`define VU_FIFO_DEPTH 16
`define VU_PTR_W 4
`define VU_CNT_W 5
`define VU_TICK_HALF 5'h07
`define VU_TICK_LAST 5'h0f
`define VU_STOP_ONE_HALF 5'h17
`define VU_STOP_TWO 5'h1f
`define VU_CHAR_MIN 4'h5
`define VU_TO_SHIFT 6

// ==========================================
// Clock rates; the reference is the 115200 Hz baud clock times 16
`define VU_CORE_CLK_HZ 125000000
`define VU_REF_HZ 115200
`define VU_OVERSAMPLE 16
`define VU_REF_CYCLES (`VU_CORE_CLK_HZ / (`VU_REF_HZ * `VU_OVERSAMPLE))

`endif

// ---- rtl/vu_pkg.sv ----
// Types shared by the virtual serial port modules.
package vu_pkg;

	// ==========================================
	// Receiver and transmitter states
	typedef enum logic [2:0] {
		vu_rx_idle = 3'b000,
		vu_rx_start = 3'b001,
		vu_rx_data = 3'b010,
		vu_rx_par = 3'b011,
		vu_rx_stop = 3'b100,
		vu_rx_wait = 3'b101
	} vu_rx_state_e;

	typedef enum logic [2:0] {
		vu_tx_idle = 3'b000,
		vu_tx_start = 3'b001,
		vu_tx_data = 3'b010,
		vu_tx_par = 3'b011,
		vu_tx_stop = 3'b100
	} vu_tx_state_e;

endpackage

// ---- rtl/vu_fifo.sv ----
// Sixteen-entry synchronous FIFO with flush, head word shown without a pop.
`timescale 1ns/1ps
`include "vu_regs.svh"

module vu_fifo #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Fill and drain
	input wire logic push,
	input wire logic pop,
	input wire logic flush,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout,
	// Level
	output logic [`VU_CNT_W-1:0] count,
	output logic full,
	output logic empty
);
	logic [WIDTH-1:0] mem [`VU_FIFO_DEPTH];
	logic [`VU_PTR_W-1:0] wr_ptr;
	logic [`VU_PTR_W-1:0] rd_ptr;
	logic push_ok;
	logic pop_ok;

	assign empty = (count == '0);
	assign full = (count == `VU_CNT_W'(`VU_FIFO_DEPTH));
	assign pop_ok = pop & !empty;
	// A push into a full FIFO is only taken when a pop frees a slot in the same cycle.
	assign push_ok = push & (!full | pop_ok);
	assign dout = mem[rd_ptr];

	always_ff @(posedge core_clk) begin
		if (push_ok) begin
			mem[wr_ptr] <= din;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push_ok) begin
				wr_ptr <= wr_ptr + `VU_PTR_W'(1);
			end
			if (pop_ok) begin
				rd_ptr <= rd_ptr + `VU_PTR_W'(1);
			end
			if (push_ok && !pop_ok) begin
				count <= count + `VU_CNT_W'(1);
			end else if (pop_ok && !push_ok) begin
				count <= count - `VU_CNT_W'(1);
			end
		end
	end
endmodule

// ---- rtl/vu_baud.sv ----
// Baud generator: 16x oversample enable pulse from the divisor latches.
`timescale 1ns/1ps
`include "vu_regs.svh"

module vu_baud (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Divisor and enable out
	input wire logic [15:0] divisor,
	output logic tick16
);
	localparam logic [6:0] REF_LAST = 7'(`VU_REF_CYCLES - 1);
	logic [6:0] ref_cnt;
	logic [15:0] div_cnt;
	logic ref_tick;

	assign ref_tick = (ref_cnt == REF_LAST);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ref_cnt <= '0;
		end else if (ref_tick) begin
			ref_cnt <= '0;
		end else begin
			ref_cnt <= ref_cnt + 7'h01;
		end
	end

	// A divisor of zero stops the line rather than dividing by 65536.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			div_cnt <= '0;
			tick16 <= 1'b0;
		end else begin
			tick16 <= 1'b0;
			if (ref_tick && divisor != 16'h0000) begin
				if (div_cnt >= divisor - 16'h0001) begin
					div_cnt <= '0;
					tick16 <= 1'b1;
				end else begin
					div_cnt <= div_cnt + 16'h0001;
				end
			end
		end
	end
endmodule

// ---- bench/vu_line_peer.sv ----
// Far end of the serial line: a plain loopback of our transmit line.
`timescale 1ns/1ps

module vu_line_peer (
	// Line
	input wire logic tx_line,
	output logic rx_line
);
	// Echoing means a break we send comes straight back as a received break.
	assign rx_line = tx_line;
endmodule

// ---- bench/vu_port_properties.sv ----
// Concurrent checks on the ports of the virtual serial port.
`timescale 1ns/1ps

module vu_port_properties (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Host I/O port
	input wire logic [2:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [7:0] host_wdata,
	input wire logic [7:0] host_rdata,
	// Line and pins
	input wire logic serial_tx,
	input wire logic term_ready_pin,
	input wire logic req_send_pin
);
	logic divisor_access_select;

	// ========
	// Divisor access shadow, needed to tell data writes apart.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			divisor_access_select <= 1'b0;
		end else if (host_wr && host_addr == 3'h3) begin
			divisor_access_select <= host_wdata[7];
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// ========
	// Properties
	AST_DTR_PIN: assert property (host_wr && host_addr == 3'h4
		|-> ##3 term_ready_pin == !$past(host_wdata[0], 3)) else $error("dtr pin wrong");
	AST_RTS_PIN: assert property (host_wr && host_addr == 3'h4
		|-> ##3 req_send_pin == !$past(host_wdata[1], 3)) else $error("rts pin wrong");
	AST_IDENT_FIFO: assert property (host_rd && host_addr == 3'h2
		|=> host_rdata[7:4] == 4'h8) else $error("fifo mode not shown");
	AST_IDENT_CODE: assert property (host_rd && host_addr == 3'h2
		|=> host_rdata[3:0] inside {4'h1, 4'h6, 4'h4, 4'hc, 4'h2, 4'h0})
		else $error("bad ident code");
	AST_TEMT_TX_HOLDING_EMPTY: assert property (host_rd && host_addr == 3'h5
		|=> !host_rdata[6] || host_rdata[5]) else $error("temt without tx_holding_empty");
	AST_WRITE_BUSY: assert property (host_wr && host_addr == 3'h0 && !divisor_access_select
		##2 host_rd && host_addr == 3'h5 |=> !host_rdata[6]) else $error("temt after write");
	AST_BREAK_LINE: assert property (host_wr && host_addr == 3'h3 && host_wdata[6]
		|-> ##3 !serial_tx) else $error("break not on line");
	AST_READ_HOLD: assert property (!host_rd
		|=> $stable(host_rdata)) else $error("read data moved");
endmodule

bind vu_port vu_port_properties vu_port_properties_i (.core_clk, .rst_n, .host_addr,
	.host_rd, .host_wr, .host_wdata, .host_rdata, .serial_tx, .term_ready_pin,
	.req_send_pin);

// ---- bench/vu_port_test.sv ----
// Self-checking bench for the virtual serial port through its host registers.
`timescale 1ns/1ps

module vu_port_test;
	logic core_clk;
	logic rst_n;
	logic [2:0] host_addr;
	logic host_rd;
	logic host_wr;
	logic [7:0] host_wdata;
	logic [7:0] host_rdata;
	logic host_irq;
	logic serial_rx;
	logic serial_tx;
	logic cts_pin;
	logic dsr_pin;
	logic ri_pin;
	logic dcd_pin;
	logic term_ready_pin;
	logic req_send_pin;
	logic rx_ready_indicator_n;
	logic tx_ready_indicator_n;
	int bad_count;
	int num_checks;

	vu_port vu_port_i (.core_clk, .rst_n, .host_addr, .host_rd, .host_wr, .host_wdata,
		.host_rdata, .host_irq, .serial_rx, .serial_tx, .cts_pin, .dsr_pin,
		.ri_pin, .dcd_pin, .term_ready_pin, .req_send_pin,
		.rx_ready_indicator_n, .tx_ready_indicator_n);
	vu_line_peer vu_line_peer_i (.tx_line(serial_tx), .rx_line(serial_rx));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// ========
	// Tasks
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		host_addr <= a;
		host_wdata <= d;
		host_wr <= 1'b1;
		@(posedge core_clk);
		host_wr <= 1'b0;
	endtask

	task automatic rc(input logic [2:0] a, input logic [7:0] e, input string n);
		@(posedge core_clk);
		host_addr <= a;
		host_rd <= 1'b1;
		@(posedge core_clk);
		host_rd <= 1'b0;
		@(posedge core_clk);
		#1;
		chk(n, e, host_rdata);
	endtask

	// A frame at divisor one takes about eleven thousand cycles.
	task automatic wait_irq();
		for (int i = 0; i < 20000 && host_irq !== 1'b1; i++) begin
			@(posedge core_clk);
		end
		chk("irq", 8'h01, {7'h00, host_irq});
		repeat (1500) @(posedge core_clk);
	endtask

	task automatic end_of_test();
		if (bad_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge core_clk);
		bad_count++;
		end_of_test();
	end

	// ========
	// Sequence
	initial begin
		rst_n = 1'b0;
		host_addr = 3'h0;
		host_rd = 1'b0;
		host_wr = 1'b0;
		host_wdata = 8'h00;
		cts_pin = 1'b0;
		dsr_pin = 1'b0;
		ri_pin = 1'b0;
		dcd_pin = 1'b0;
		bad_count = 0;
		num_checks = 0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		rc(3'h5, 8'h60, "status");
		rc(3'h2, 8'h81, "ident");
		chk("tx_ready_indicator", 8'h00, {7'h00, tx_ready_indicator_n});
		for (int v = 0; v < 4; v++) begin
			wr(3'h4, 8'(v));
			rc(3'h4, 8'(v), "hsk");
			chk("dtr", {7'h00, ~v[0]}, {7'h00, term_ready_pin});
			chk("rts", {7'h00, ~v[1]}, {7'h00, req_send_pin});
		end
		wr(3'h3, 8'h80);
		wr(3'h0, 8'h01);
		wr(3'h1, 8'h00);
		wr(3'h3, 8'h03);
		wr(3'h1, 8'h02);
		repeat (3) @(posedge core_clk);
		chk("irq", 8'h01, {7'h00, host_irq});
		rc(3'h2, 8'h82, "ident");
		rc(3'h2, 8'h81, "ident");
		wr(3'h1, 8'h08);
		@(posedge core_clk);
		cts_pin <= 1'b1;
		dsr_pin <= 1'b1;
		ri_pin <= 1'b1;
		dcd_pin <= 1'b1;
		repeat (6) @(posedge core_clk);
		rc(3'h2, 8'h80, "ident");
		rc(3'h6, 8'hff, "mstat");
		rc(3'h2, 8'h81, "ident");
		wr(3'h1, 8'h01);
		wr(3'h2, 8'h01);
		wr(3'h0, 8'ha5);
		rc(3'h5, 8'h20, "status");
		wait_irq();
		rc(3'h2, 8'h84, "ident");
		rc(3'h0, 8'ha5, "data");
		rc(3'h5, 8'h60, "status");
		wr(3'h3, 8'h1a);
		wr(3'h0, 8'hff);
		wait_irq();
		chk("rx_ready_indicator", 8'h00, {7'h00, rx_ready_indicator_n});
		rc(3'h5, 8'h61, "status");
		wr(3'h2, 8'h03);
		rc(3'h5, 8'h60, "status");
		wr(3'h1, 8'h04);
		wr(3'h3, 8'h43);
		wait_irq();
		wr(3'h3, 8'h03);
		rc(3'h2, 8'h86, "ident");
		rc(3'h5, 8'hf1, "status");
		rc(3'h0, 8'h00, "data");
		rc(3'h5, 8'h60, "status");
		end_of_test();
	end
endmodule
